// ==== cgs_pkg.sv ====
`default_nettype none
package cgs_pkg;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [13:0] OFS_STATUS = 14'h0000;
    localparam logic [13:0] OFS_OSC_CTRL = 14'h0004;
    localparam logic [13:0] OFS_TRIM = 14'h0008;
    localparam logic [13:0] OFS_USB_CTRL = 14'h000c;
    localparam logic [13:0] OFS_USB_FB_DIV = 14'h0010;
    localparam logic [13:0] OFS_USB_PP_DIV = 14'h0014;
    localparam logic [13:0] OFS_RF1_CTRL = 14'h0018;
    localparam logic [13:0] OFS_RF2_CTRL = 14'h001c;
    localparam logic [13:0] OFS_RF_GLOB = 14'h0020;
    localparam logic [13:0] OFS_DET_CTRL = 14'h0024;
    localparam logic [13:0] OFS_RSVD = 14'h0028;
    localparam logic [13:0] OFS_PRES_BYP = 14'h002c;

    // reset values
    localparam logic [31:0] RST_STATUS = 32'h0000_0000;
    localparam logic [31:0] RST_OSC_CTRL = 32'h00ff_f001;
    localparam logic [31:0] RST_TRIM = 32'h0000_0000;
    localparam logic [31:0] RST_USB_CTRL = 32'h00f9_0001;
    localparam logic [31:0] RST_USB_FB_DIV = 32'h0000_0000;
    localparam logic [31:0] RST_USB_PP_DIV = 32'h0000_0000;
    localparam logic [31:0] RST_RF1_CTRL = 32'h02e3_b190;
    localparam logic [31:0] RST_RF2_CTRL = 32'h02e1_21e0;
    localparam logic [31:0] RST_RF_GLOB = 32'h0000_00c8;
    localparam logic [31:0] RST_DET_CTRL = 32'h0000_100d;
    localparam logic [31:0] RST_RSVD = 32'h0000_000f;
    localparam logic [31:0] RST_PRES_BYP = 32'h0000_0000;

    // writable bit masks; oscillator control keeps bits 23:0 only
    localparam logic [31:0] MASK_OSC_CTRL = 32'h00ff_ffff;
    localparam logic [31:0] MASK_TRIM = 32'h0000_001f;
    localparam logic [31:0] MASK_ALL = 32'hffff_ffff;

    // oscillator control fields
    localparam int OSC_TIMEOUT_LSB = 12;
    localparam int OSC_TIMEOUT_W = 12;
    localparam int OSC_XTAL_DET_EN_BIT = 11;

    // hardware status inputs, gathered
    typedef struct packed {
        logic rf_second_lock_signal;
        logic xtal_timeout;
        logic xtal_clk_present;
        logic xtal_osc_ready;
        logic rf_second_lock_bypass;
        logic rf_detect_done;
        logic rf_clk_in_ok;
        logic rf_second_pll_locked;
        logic rf_first_pll_locked;
        logic xtal_activated;
        logic xtal_enabled;
        logic [7:0] usb_edge_count;
        logic usb_detect_done;
        logic usb_clk_in_ok;
        logic usb_pll_free_running;
        logic post_divider_change_ack;
        logic pre_divider_change_ack;
        logic feedback_divider_change_ack;
        logic usb_pll_lock_bypass;
        logic usb_pll_lock;
    } cgs_hw_status_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } cgs_bus_req_t;
endpackage : cgs_pkg
`default_nettype wire

// ==== cgs_sync.sv ====
`default_nettype none
module cgs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule : cgs_sync
`default_nettype wire

// ==== cgs_rw_reg.sv ====
`default_nettype none
module cgs_rw_reg #(
    parameter logic [31:0] RESET_VAL = 32'h0000_0000,
    parameter logic [31:0] WR_MASK = 32'hffff_ffff
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic wr_en,
    input wire logic [31:0] wdata,
    output logic [31:0] value
);
    logic [31:0] value_reg;
    logic [31:0] value_next;

    // masked bits keep their contents
    assign value_next = (wdata & WR_MASK) | (value_reg & ~WR_MASK);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            value_reg <= RESET_VAL;
        end else if (wr_en) begin
            value_reg <= value_next;
        end
    end

    assign value = value_reg;
endmodule : cgs_rw_reg
`default_nettype wire

// ==== cgs_clock_status_regs.sv ====
`default_nettype none
// Overview of operation
// [RL1] twelve 32-bit registers decoded by offset from the block base address
// [RL2] status at offset zero is read-only and resets to all zero
// [RL3] bit 26 mirrors the second rf pll lock output
// [RL4] bit 25 flags crystal activation timeout
// [RL5] bit 24 shows crystal clock present, only while presence detection enabled
// [RL6] bit 23 high when crystal oscillator clock ready
// [RL7] bit 22 is second rf pll lock or its lock bypass
// [RL8] bit 21 set when rf pll input clock detection completed
// [RL9] bit 20 one when rf pll input clock present and correct
// [RL10] bits 19 and 18 mirror second and first rf pll lock
// [RL11] bit 17 crystal activated, bit 16 crystal enabled
// [RL12] bits 15:8 hold captured usb input clock edge count
// [RL13] bit 7 set when usb input clock detection completed
// [RL14] bit 6 set when usb input clock present with matching frequency
// [RL15] bit 5 set while usb pll runs free
// [RL16] bits 4,3,2 post, pre, feedback divider change acknowledges
// [RL17] bit 1 is usb pll lock or usb lock bypass
// [RL18] bit 0 reflects usb pll lock
// [RL19] writes to unused oscillator control bits are ignored
// [RL20] crystal timeout field bits 23:12, reset all ones
// [RL21] status driven from synchronised inputs; reads harmless, writes ignored
module cgs_clock_status_regs
    import cgs_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [cgs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [cgs_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [cgs_pkg::DATA_W-1:0] reg_rdata,
    input wire cgs_pkg::cgs_hw_status_t hw_status,
    output logic [cgs_pkg::OSC_TIMEOUT_W-1:0] xtal_activation_timeout,
    output logic xtal_detect_enable,
    output logic [31:0] osc_ctrl_value,
    output logic [31:0] trim_value,
    output logic [31:0] usb_ctrl_value,
    output logic [31:0] usb_fb_div_value,
    output logic [31:0] usb_pp_div_value,
    output logic [31:0] rf1_ctrl_value,
    output logic [31:0] rf2_ctrl_value,
    output logic [31:0] rf_glob_value,
    output logic [31:0] det_ctrl_value,
    output logic [31:0] pres_byp_value
);
    import cgs_pkg::*;

    localparam int NREG = 12;
    localparam int STAT_W = $bits(cgs_hw_status_t);

    // decoded register select
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // all pins cross into core_clk before use [RL21]
    cgs_hw_status_t hw_sync;
    logic [STAT_W-1:0] hw_sync_bits;

    cgs_sync #(
        .WIDTH(STAT_W)
    ) u_sync (
        .core_clk(core_clk),
        .srst(srst),
        .async_in(hw_status),
        .sync_out(hw_sync_bits)
    );

    assign hw_sync = cgs_hw_status_t'(hw_sync_bits);

    // write strobes per register [RL1]
    wire logic [NREG-1:0] wr_sel;
    assign wr_sel[0] = 1'b0; // status takes no writes [RL2] [RL21]
    assign wr_sel[1] = reg_wr && hit(reg_addr, OFS_OSC_CTRL);
    assign wr_sel[2] = reg_wr && hit(reg_addr, OFS_TRIM);
    assign wr_sel[3] = reg_wr && hit(reg_addr, OFS_USB_CTRL);
    assign wr_sel[4] = reg_wr && hit(reg_addr, OFS_USB_FB_DIV);
    assign wr_sel[5] = reg_wr && hit(reg_addr, OFS_USB_PP_DIV);
    assign wr_sel[6] = reg_wr && hit(reg_addr, OFS_RF1_CTRL);
    assign wr_sel[7] = reg_wr && hit(reg_addr, OFS_RF2_CTRL);
    assign wr_sel[8] = reg_wr && hit(reg_addr, OFS_RF_GLOB);
    assign wr_sel[9] = reg_wr && hit(reg_addr, OFS_DET_CTRL);
    assign wr_sel[10] = reg_wr && hit(reg_addr, OFS_RSVD);
    assign wr_sel[11] = reg_wr && hit(reg_addr, OFS_PRES_BYP);

    logic [31:0] rsvd_value;

    // unused bits 31:24 refuse writes [RL19]
    cgs_rw_reg #(.RESET_VAL(RST_OSC_CTRL), .WR_MASK(MASK_OSC_CTRL)) u_osc (
        .core_clk(core_clk), .srst(srst), .wr_en(wr_sel[1]),
        .wdata(reg_wdata), .value(osc_ctrl_value));
    cgs_rw_reg #(.RESET_VAL(RST_TRIM), .WR_MASK(MASK_TRIM)) u_trim (
        .core_clk(core_clk), .srst(srst), .wr_en(wr_sel[2]),
        .wdata(reg_wdata), .value(trim_value));
    cgs_rw_reg #(.RESET_VAL(RST_USB_CTRL), .WR_MASK(MASK_ALL)) u_usb (
        .core_clk(core_clk), .srst(srst), .wr_en(wr_sel[3]),
        .wdata(reg_wdata), .value(usb_ctrl_value));
    cgs_rw_reg #(.RESET_VAL(RST_USB_FB_DIV), .WR_MASK(MASK_ALL)) u_fb (
        .core_clk(core_clk), .srst(srst), .wr_en(wr_sel[4]),
        .wdata(reg_wdata), .value(usb_fb_div_value));
    cgs_rw_reg #(.RESET_VAL(RST_USB_PP_DIV), .WR_MASK(MASK_ALL)) u_pp (
        .core_clk(core_clk), .srst(srst), .wr_en(wr_sel[5]),
        .wdata(reg_wdata), .value(usb_pp_div_value));
    cgs_rw_reg #(.RESET_VAL(RST_RF1_CTRL), .WR_MASK(MASK_ALL)) u_rf1 (
        .core_clk(core_clk), .srst(srst), .wr_en(wr_sel[6]),
        .wdata(reg_wdata), .value(rf1_ctrl_value));
    cgs_rw_reg #(.RESET_VAL(RST_RF2_CTRL), .WR_MASK(MASK_ALL)) u_rf2 (
        .core_clk(core_clk), .srst(srst), .wr_en(wr_sel[7]),
        .wdata(reg_wdata), .value(rf2_ctrl_value));
    cgs_rw_reg #(.RESET_VAL(RST_RF_GLOB), .WR_MASK(MASK_ALL)) u_glob (
        .core_clk(core_clk), .srst(srst), .wr_en(wr_sel[8]),
        .wdata(reg_wdata), .value(rf_glob_value));
    cgs_rw_reg #(.RESET_VAL(RST_DET_CTRL), .WR_MASK(MASK_ALL)) u_det (
        .core_clk(core_clk), .srst(srst), .wr_en(wr_sel[9]),
        .wdata(reg_wdata), .value(det_ctrl_value));
    cgs_rw_reg #(.RESET_VAL(RST_RSVD), .WR_MASK(MASK_ALL)) u_rsvd (
        .core_clk(core_clk), .srst(srst), .wr_en(wr_sel[10]),
        .wdata(reg_wdata), .value(rsvd_value));
    cgs_rw_reg #(.RESET_VAL(RST_PRES_BYP), .WR_MASK(MASK_ALL)) u_byp (
        .core_clk(core_clk), .srst(srst), .wr_en(wr_sel[11]),
        .wdata(reg_wdata), .value(pres_byp_value));

    // timeout field, counted in slow clock cycles plus eight downstream [RL20]
    assign xtal_activation_timeout =
        osc_ctrl_value[OSC_TIMEOUT_LSB +: OSC_TIMEOUT_W];
    assign xtal_detect_enable = osc_ctrl_value[OSC_XTAL_DET_EN_BIT];

    // status word, bits 31:27 read zero
    logic [31:0] status_reg;
    logic [31:0] status_next;

    assign status_next = {
        5'h00,
        hw_sync.rf_second_lock_signal, // [RL3]
        hw_sync.xtal_timeout, // [RL4]
        hw_sync.xtal_clk_present & xtal_detect_enable, // [RL5]
        hw_sync.xtal_osc_ready, // [RL6]
        hw_sync.rf_second_pll_locked | hw_sync.rf_second_lock_bypass, // [RL7]
        hw_sync.rf_detect_done, // [RL8]
        hw_sync.rf_clk_in_ok, // [RL9]
        hw_sync.rf_second_pll_locked, // [RL10]
        hw_sync.rf_first_pll_locked, // [RL10]
        hw_sync.xtal_activated, // [RL11]
        hw_sync.xtal_enabled, // [RL11]
        hw_sync.usb_edge_count, // [RL12]
        hw_sync.usb_detect_done, // [RL13]
        hw_sync.usb_clk_in_ok & hw_sync.usb_detect_done, // [RL14]
        hw_sync.usb_pll_free_running, // [RL15]
        hw_sync.post_divider_change_ack, // [RL16]
        hw_sync.pre_divider_change_ack, // [RL16]
        hw_sync.feedback_divider_change_ack, // [RL16]
        hw_sync.usb_pll_lock | hw_sync.usb_pll_lock_bypass, // [RL17]
        hw_sync.usb_pll_lock // [RL18]
    };

    // edge count only captured on a good detection, held otherwise [RL12]
    wire logic cnt_capture = hw_sync.usb_detect_done & hw_sync.usb_clk_in_ok;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            status_reg <= RST_STATUS; // [RL2]
        end else begin
            status_reg <= cnt_capture ? status_next
                : {status_next[31:16], status_reg[15:8], status_next[7:0]};
        end
    end

    // read mux; unmapped offsets read zero [RL1]
    logic [31:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            OFS_STATUS: rd_mux = status_reg;
            OFS_OSC_CTRL: rd_mux = osc_ctrl_value;
            OFS_TRIM: rd_mux = trim_value;
            OFS_USB_CTRL: rd_mux = usb_ctrl_value;
            OFS_USB_FB_DIV: rd_mux = usb_fb_div_value;
            OFS_USB_PP_DIV: rd_mux = usb_pp_div_value;
            OFS_RF1_CTRL: rd_mux = rf1_ctrl_value;
            OFS_RF2_CTRL: rd_mux = rf2_ctrl_value;
            OFS_RF_GLOB: rd_mux = rf_glob_value;
            OFS_DET_CTRL: rd_mux = det_ctrl_value;
            OFS_RSVD: rd_mux = rsvd_value;
            OFS_PRES_BYP: rd_mux = pres_byp_value;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read has no side effect [RL21]
    logic [31:0] rdata_reg;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (reg_rd) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_reg;
endmodule : cgs_clock_status_regs
`default_nettype wire

// ==== cgs_status_monitor.sv ====
`default_nettype none
module cgs_status_monitor
    import cgs_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [cgs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [cgs_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [cgs_pkg::DATA_W-1:0] reg_rdata,
    input wire cgs_pkg::cgs_hw_status_t hw_status,
    input wire logic [cgs_pkg::OSC_TIMEOUT_W-1:0] xtal_activation_timeout,
    input wire logic xtal_detect_enable,
    input wire logic [31:0] osc_ctrl_value,
    input wire logic [31:0] trim_value
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    a_rdata_idle_zero: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside read slot");
    a_osc_read_back: assert property (
        $past(reg_rd) && $past(reg_addr) == OFS_OSC_CTRL |-> reg_rdata == $past(osc_ctrl_value))
        else $error("oscillator control read mismatch");
    a_osc_write_mask: assert property (
        reg_wr && reg_addr == OFS_OSC_CTRL |=> osc_ctrl_value == ($past(reg_wdata) & MASK_OSC_CTRL))
        else $error("oscillator control write mismatch");
    a_status_write_ignored: assert property (
        reg_wr && reg_addr == OFS_STATUS |=> $stable(osc_ctrl_value) && $stable(trim_value))
        else $error("status write disturbed a register");
    a_timeout_field: assert property (
        xtal_activation_timeout == osc_ctrl_value[23:12] && xtal_detect_enable == osc_ctrl_value[11])
        else $error("timeout or detect enable not taken from register");
    a_osc_reset_value: assert property (
        $fell(srst) |-> osc_ctrl_value == RST_OSC_CTRL) else $error("oscillator reset value");
    a_trim_upper_zero: assert property (
        trim_value[31:5] == 27'h0) else $error("trim upper bits written");
    // inputs held over the sync window so the latency guess cannot matter
    a_usb_lock_or: assert property (
        $past(reg_rd) && $past(reg_addr) == OFS_STATUS && $past(hw_status, 3) == $past(hw_status, 4)
        && $past(hw_status, 4) == $past(hw_status, 5)
        |-> reg_rdata[1] == ($past(hw_status.usb_pll_lock, 4) | $past(hw_status.usb_pll_lock_bypass, 4)))
        else $error("usb lock override bit wrong");
endmodule : cgs_status_monitor
bind cgs_clock_status_regs cgs_status_monitor u_mon (.core_clk(core_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .hw_status(hw_status), .xtal_activation_timeout(xtal_activation_timeout),
    .xtal_detect_enable(xtal_detect_enable), .osc_ctrl_value(osc_ctrl_value), .trim_value(trim_value));
`default_nettype wire

// ==== clock_generator_status_regs_bench.sv ====
`default_nettype none
module clock_generator_status_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import cgs_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    cgs_hw_status_t hw_status = '0;
    logic [11:0] tmo;
    logic det_en;
    logic [7:0] cnt = 8'h0;
    logic [31:0] r;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [13:0] addrs [12] = '{OFS_STATUS, OFS_OSC_CTRL, OFS_TRIM, OFS_USB_CTRL, OFS_USB_FB_DIV,
        OFS_USB_PP_DIV, OFS_RF1_CTRL, OFS_RF2_CTRL, OFS_RF_GLOB, OFS_DET_CTRL, OFS_RSVD, OFS_PRES_BYP};
    logic [31:0] rsts [12] = '{RST_STATUS, RST_OSC_CTRL, RST_TRIM, RST_USB_CTRL, RST_USB_FB_DIV,
        RST_USB_PP_DIV, RST_RF1_CTRL, RST_RF2_CTRL, RST_RF_GLOB, RST_DET_CTRL, RST_RSVD, RST_PRES_BYP};
    cgs_clock_status_regs dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .hw_status(hw_status), .xtal_activation_timeout(tmo), .xtal_detect_enable(det_en),
        .osc_ctrl_value(), .trim_value(), .usb_ctrl_value(), .usb_fb_div_value(),
        .usb_pp_div_value(), .rf1_ctrl_value(), .rf2_ctrl_value(), .rf_glob_value(),
        .det_ctrl_value(), .pres_byp_value());
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    // whole run needs about 480 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            results();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // tasks start 1 ns after an edge and end there, so calls chain back to back
    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [13:0] a, input logic [31:0] e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, e);
    endtask : rd
    function automatic logic [31:0] exp_status(input cgs_hw_status_t h, input logic en);
        return {5'h0, h.rf_second_lock_signal, h.xtal_timeout, h.xtal_clk_present & en,
            h.xtal_osc_ready, h.rf_second_pll_locked | h.rf_second_lock_bypass, h.rf_detect_done,
            h.rf_clk_in_ok, h.rf_second_pll_locked, h.rf_first_pll_locked, h.xtal_activated,
            h.xtal_enabled, cnt, h.usb_detect_done, h.usb_clk_in_ok & h.usb_detect_done,
            h.usb_pll_free_running, h.post_divider_change_ack, h.pre_divider_change_ack,
            h.feedback_divider_change_ack, h.usb_pll_lock | h.usb_pll_lock_bypass, h.usb_pll_lock};
    endfunction : exp_status
    initial begin
        void'($urandom(68));
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        #1;
        for (int i = 0; i < 12; i++) rd(addrs[i], rsts[i]);
        wr(14'h0030, 32'hffff_ffff);
        rd(14'h3ffc, 32'h0);
        for (int i = 1; i < 12; i++) begin
            r = $urandom();
            wr(addrs[i], r);
            wr(OFS_STATUS, ~r);
            rd(addrs[i], r & (i == 1 ? MASK_OSC_CTRL : i == 2 ? MASK_TRIM : MASK_ALL));
            rd(OFS_STATUS, 32'h0);
        end
        for (int i = 0; i < 40; i++) begin
            r = $urandom();
            wr(OFS_OSC_CTRL, r);
            check({20'h0, tmo}, {20'h0, r[23:12]});
            check({31'h0, det_en}, {31'h0, r[11]});
            hw_status <= (i == 0) ? '1 : (i == 1) ? '0 : 27'($urandom());
            repeat (6) @(posedge core_clk);
            #1;
            if (hw_status.usb_detect_done && hw_status.usb_clk_in_ok) cnt = hw_status.usb_edge_count;
            rd(OFS_STATUS, exp_status(hw_status, r[11]));
            rd(OFS_STATUS, exp_status(hw_status, r[11]));
            rd(OFS_STATUS, exp_status(hw_status, r[11]));
        end
        results();
    end
endmodule : clock_generator_status_regs_bench
`default_nettype wire
